// file: shared/ipr_pkg.sv
package ipr_pkg;
	localparam int          IPR_NREG      = 6;
	localparam int          IPR_NSRC      = 20;
	localparam int          IPR_LW        = 3;
	localparam logic [2:0]  IPR_LVL_RST   = 3'h4;
	localparam logic [2:0]  IPR_LVL_OFF   = 3'h0;
	localparam logic [15:0] IPR_MASK_FULL = 16'h7777;
	localparam logic [15:0] IPR_MASK_3    = 16'h0777;
	localparam logic [15:0] IPR_MASK_5    = 16'h0007;
	localparam logic [15:0] IPR_RST_FULL  = 16'h4444;
	localparam logic [15:0] IPR_RST_3     = 16'h0444;
	localparam logic [15:0] IPR_RST_5     = 16'h0004;
	localparam logic [7:0]  IPR_OFF_CTRL0 = 8'h00;
	localparam logic [7:0]  IPR_OFF_CTRL1 = 8'h04;
	localparam logic [7:0]  IPR_OFF_CTRL2 = 8'h08;
	localparam logic [7:0]  IPR_OFF_CTRL3 = 8'h0C;
	localparam logic [7:0]  IPR_OFF_CTRL4 = 8'h10;
	localparam logic [7:0]  IPR_OFF_CTRL5 = 8'h14;
	localparam logic [7:0]  IPR_OFF_STAT  = 8'h18;
	localparam logic [1:0]  IPR_RESP_OK   = 2'h0;
	localparam logic [1:0]  IPR_RESP_ERR  = 2'h2;
	// Source index order: register n field k (k=3 at bits 14-12) -> 4*n + (3-k)
	localparam int          IPR_SRC_T1    = 0;
	localparam int          IPR_SRC_INT1  = 20;
endpackage

// file: shared/ipr_arb_if.sv
`timescale 1ns/1ns
interface ipr_arb_if;
	logic [20*3-1:0] levels;
	logic [19:0]     pend;
	logic            req;
	logic [4:0]      id;
	logic [2:0]      lvl;
	modport regs (output levels, output pend, input req, input id, input lvl);
	modport arb  (input levels, input pend, output req, output id, output lvl);
endinterface

// file: hw/ipr_arbiter.sv
`timescale 1ns/1ns
module ipr_arbiter
	import ipr_pkg::*;
(
	ipr_arb_if.arb a
);
	logic [2:0] best_lvl [0:IPR_NSRC];
	logic [4:0] best_id  [0:IPR_NSRC];
	assign best_lvl[0] = IPR_LVL_OFF;
	assign best_id[0]  = 5'h00;
	// Strictly greater: lower index wins among equal levels
	for (genvar i = 0; i < IPR_NSRC; i++) begin : g_cmp
		wire [2:0] lv   = a.levels[i*IPR_LW +: IPR_LW];
		wire       take = a.pend[i] && (lv != IPR_LVL_OFF) && (lv > best_lvl[i]); // [R3] [R12]
		assign best_lvl[i+1] = take ? lv : best_lvl[i];
		assign best_id[i+1]  = take ? 5'(i) : best_id[i];
	end
	assign a.req = best_lvl[IPR_NSRC] != IPR_LVL_OFF; // [R1] [R2]
	assign a.lvl = best_lvl[IPR_NSRC];
	assign a.id  = best_id[IPR_NSRC];
endmodule

// file: hw/ipr_regs.sv
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
// Behaviour
// [R1] Level code 111 is priority 7, the highest.
// [R2] Level code 001 is priority 1, the lowest active level.
// [R3] Level code 000 disables the source; it never reaches the processor.
// [R4] Every implemented field resets to 100, level 4; all fields read/write.
// [R5] Unimplemented bits read zero and ignore writes.
// [R6] Register 0: timer1, out-compare1, in-capture1, ext irq0 fields.
// [R7] Register 1: timer2, out-compare2, in-capture2, dma ch0 fields.
// [R8] Register 2: serial1 rx, spi1 event, spi1 error, timer3 fields.
// [R9] Register 3: bits 15-11 unused; dma ch1, adc done, serial1 tx.
// [R10] Register 4: change notify, comparator1, i2c1 master, i2c1 slave fields.
// [R11] Register 5: bits 15-3 unused; bits 2-0 hold ext irq1. The code stores this field but feeds it to no arbiter source.
// [R12] Codes 010..110 are levels 2..6; higher level is served first.
module ipr_regs
	import ipr_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [19:0] src_pending,
	output logic             irq_req,
	output logic [4:0]       irq_id,
	output logic [2:0]       irq_level
);
	ipr_arb_if arb_bus ();

	logic [15:0] ctrl_ff [0:IPR_NREG-1];
	logic [15:0] nxt_ctrl [0:IPR_NREG-1];
	logic [15:0] reg_mask [0:IPR_NREG-1];
	logic [15:0] reg_rst  [0:IPR_NREG-1];

	logic        aw_got_ff;
	logic [7:0]  aw_addr_ff;
	logic        w_got_ff;
	logic [31:0] w_data_ff;
	logic [3:0]  w_strb_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;
	logic        awready_ff;
	logic        wready_ff;
	logic        arready_ff;
	logic        irq_req_ff;
	logic [4:0]  irq_id_ff;
	logic [2:0]  irq_level_ff;
	logic [19:0] pend_ff;

	// Field masks and reset images per register
	assign reg_mask[0] = IPR_MASK_FULL; // [R6]
	assign reg_mask[1] = IPR_MASK_FULL; // [R7]
	assign reg_mask[2] = IPR_MASK_FULL; // [R8]
	assign reg_mask[3] = IPR_MASK_3;    // [R9]
	assign reg_mask[4] = IPR_MASK_FULL; // [R10]
	assign reg_mask[5] = IPR_MASK_5;    // [R11]
	assign reg_rst[0]  = IPR_RST_FULL;
	assign reg_rst[1]  = IPR_RST_FULL;
	assign reg_rst[2]  = IPR_RST_FULL;
	assign reg_rst[3]  = IPR_RST_3;
	assign reg_rst[4]  = IPR_RST_FULL;
	assign reg_rst[5]  = IPR_RST_5;

	// Write path: address and data taken in either order
	wire        aw_take   = s_axi_awvalid && awready_ff;
	wire        w_take    = s_axi_wvalid && wready_ff;
	wire        aw_have   = aw_got_ff || aw_take;
	wire        w_have    = w_got_ff || w_take;
	wire [7:0]  wr_addr   = aw_got_ff ? aw_addr_ff : s_axi_awaddr;
	wire [31:0] wr_data   = w_got_ff ? w_data_ff : s_axi_wdata;
	wire [3:0]  wr_strb   = w_got_ff ? w_strb_ff : s_axi_wstrb;
	wire        wr_fire   = aw_have && w_have && !bvalid_ff;
	wire [15:0] wr_lanes  = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
	wire [5:0]  wr_word   = wr_addr[7:2];
	wire        wr_hit    = (wr_addr[1:0] == 2'h0) && (wr_word < 6'(IPR_NREG));
	wire        wr_stat   = wr_addr == IPR_OFF_STAT;

	for (genvar r = 0; r < IPR_NREG; r++) begin : g_reg
		wire sel = wr_fire && wr_hit && (wr_word == 6'(r));
		// Only implemented bits take the write
		assign nxt_ctrl[r] = sel ? ((ctrl_ff[r] & ~(reg_mask[r] & wr_lanes)) |
			(wr_data[15:0] & reg_mask[r] & wr_lanes)) : ctrl_ff[r]; // [R5]
		always_ff @(posedge mclk) begin
			if (!rst_n)
				ctrl_ff[r] <= reg_rst[r]; // [R4]
			else
				ctrl_ff[r] <= nxt_ctrl[r];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			aw_got_ff  <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_got_ff   <= 1'b0;
			w_data_ff  <= 32'h00000000;
			w_strb_ff  <= 4'h0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= IPR_RESP_OK;
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
		end else begin
			if (aw_take)
				aw_addr_ff <= s_axi_awaddr;
			if (w_take) begin
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end
			aw_got_ff  <= aw_have && !wr_fire;
			w_got_ff   <= w_have && !wr_fire;
			awready_ff <= !aw_have || wr_fire ? !(aw_take && !wr_fire) && !bvalid_ff : 1'b0;
			wready_ff  <= !w_have || wr_fire ? !(w_take && !wr_fire) && !bvalid_ff : 1'b0;
			if (wr_fire) begin
				bvalid_ff <= 1'b1;
				bresp_ff  <= (wr_hit || wr_stat) ? IPR_RESP_OK : IPR_RESP_ERR;
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff  <= 1'b0;
				awready_ff <= !aw_got_ff;
				wready_ff  <= !w_got_ff;
			end
		end
	end

	// Read path
	wire        ar_take  = s_axi_arvalid && arready_ff;
	wire [5:0]  rd_word  = s_axi_araddr[7:2];
	wire        rd_hit   = (s_axi_araddr[1:0] == 2'h0) && (rd_word < 6'(IPR_NREG));
	wire        rd_stat  = s_axi_araddr == IPR_OFF_STAT;
	wire [2:0]  rd_idx   = rd_hit ? rd_word[2:0] : 3'h0;
	wire [31:0] stat_img = {20'h00000, irq_req_ff, 3'h0, irq_id_ff, irq_level_ff};
	wire [31:0] rd_img   = rd_hit ? {16'h0000, ctrl_ff[rd_idx] & reg_mask[rd_idx]} :
		rd_stat ? stat_img : 32'h00000000; // [R5]

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h00000000;
			rresp_ff   <= IPR_RESP_OK;
			arready_ff <= 1'b0;
		end else if (ar_take) begin
			rvalid_ff  <= 1'b1;
			rdata_ff   <= rd_img;
			rresp_ff   <= (rd_hit || rd_stat) ? IPR_RESP_OK : IPR_RESP_ERR;
			arready_ff <= 1'b0;
		end else if (rvalid_ff && s_axi_rready) begin
			rvalid_ff  <= 1'b0;
			arready_ff <= 1'b1;
		end else if (!rvalid_ff) begin
			arready_ff <= 1'b1;
		end
	end

	// Level fields gathered in source order for the arbiter
	for (genvar s = 0; s < IPR_NSRC; s++) begin : g_lvl
		localparam int RG = s / 4;
		localparam int FB = (3 - (s % 4)) * 4;
		assign arb_bus.levels[s*IPR_LW +: IPR_LW] = ctrl_ff[RG][FB +: IPR_LW]; // [R6] [R7] [R8] [R9] [R10]
	end
	assign arb_bus.pend = pend_ff;

	ipr_arbiter u_arb (
		.a (arb_bus.arb)
	);

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pend_ff      <= 20'h00000;
			irq_req_ff   <= 1'b0;
			irq_id_ff    <= 5'h00;
			irq_level_ff <= IPR_LVL_OFF;
		end else begin
			// Unused slots of register 3 upper field never pend
			pend_ff      <= src_pending & 20'hFFFFF & ~(20'h1 << 12);
			irq_req_ff   <= arb_bus.req; // [R3]
			irq_id_ff    <= arb_bus.id;
			irq_level_ff <= arb_bus.lvl; // [R12]
		end
	end

	assign s_axi_awready = awready_ff;
	assign s_axi_wready  = wready_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;
	assign irq_req       = irq_req_ff;
	assign irq_id        = irq_id_ff;
	assign irq_level     = irq_level_ff;
endmodule

// file: verif/ipr_src_model.sv
`timescale 1ns/1ns
module ipr_src_model (
	input  wire logic [19:0] raise,
	input  wire logic        mclk,
	output logic      [19:0] src_pending
);
	// Peripheral requests are levels, registered like a real source flag
	always_ff @(posedge mclk) begin
		src_pending <= raise;
	end
endmodule

// file: verif/ipr_regs_properties.sv
`timescale 1ns/1ns
module ipr_regs_chk
	import ipr_pkg::*;
(
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [19:0] src_pending,
	input wire logic        irq_req,
	input wire logic [2:0]  irq_level
);
	logic [7:0] ra_ff;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge mclk) begin
		if (s_axi_arvalid && s_axi_arready) begin
			ra_ff <= s_axi_araddr;
		end
	end
	chk_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper set");
	chk_rd_gap: assert property (s_axi_rvalid |-> (s_axi_rdata[15:0] & 16'h8888) == 16'h0000) else $error("gap set");
	chk_reg3_top: assert property (s_axi_rvalid && ra_ff == IPR_OFF_CTRL3 |-> s_axi_rdata[15:11] == 5'h00)
		else $error("reg3 top set");
	chk_reg5_top: assert property (s_axi_rvalid && ra_ff == IPR_OFF_CTRL5 |-> s_axi_rdata[15:3] == 13'h0000)
		else $error("reg5 top set");
	chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
	chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	chk_irq_level: assert property (irq_req |-> irq_level != IPR_LVL_OFF) else $error("level zero served");
	chk_irq_idle: assert property ((src_pending == 20'h00000) [*3] |-> !irq_req) else $error("request idle");
	cover property (s_axi_rvalid && !s_axi_rready);
	cover property (irq_req && irq_level == 3'h7);
	cover property (s_axi_rvalid && ra_ff == IPR_OFF_CTRL5);
endmodule
bind ipr_regs ipr_regs_chk u_chk (.mclk, .rst_n, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .src_pending, .irq_req, .irq_level);

// file: verif/ipr_regs_test.sv
`timescale 1ns/1ns
module ipr_regs_test
	import ipr_pkg::*;
;
	logic        mclk = 1'h0, rst_n = 1'h0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rs = 32'h26;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [19:0] raise = 20'h0, src_pending;
	logic        awready, wready, bvalid, arready, rvalid, irq_req;
	logic [1:0]  bresp, rresp, r;
	logic [31:0] rdata, d, v;
	logic [4:0]  irq_id;
	logic [2:0]  irq_level;
	logic [3:0]  p;
	logic [3:0]  wstrb = 4'hF;
	int          n_mismatch = 0;
	int          comparisons = 0;
	ipr_src_model u_src (.raise, .mclk, .src_pending);
	ipr_regs DUT (.mclk, .rst_n, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .src_pending, .irq_req, .irq_id, .irq_level);
	initial forever #20 mclk = ~mclk;
	function automatic logic [31:0] xs();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	function automatic logic [15:0] msk(input int i);
		return i == 3 ? IPR_MASK_3 : i == 5 ? IPR_MASK_5 : IPR_MASK_FULL;
	endfunction
	function automatic logic [15:0] rstv(input int i);
		return i == 3 ? IPR_RST_3 : i == 5 ? IPR_RST_5 : IPR_RST_FULL;
	endfunction
	// Highest level among pending sources of register 0, lower index on a tie
	function automatic logic [8:0] win(input logic [15:0] c, input logic [3:0] q);
		logic [2:0] b;
		logic [4:0] id;
		b = 3'h0;
		id = 5'h00;
		for (int k = 0; k < 4; k++) begin
			if (q[k] && c[14-4*k -: 3] > b) begin
				b = c[14-4*k -: 3];
				id = 5'(k);
			end
		end
		return {b != 3'h0, id, b};
	endfunction
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic tmo(input int n);
		if (n >= 50) begin
			n_mismatch++;
			report_and_stop();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] q, output logic [1:0] e);
		int n;
		@(posedge mclk);
		awaddr <= a;
		wdata <= q;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (n = 0; n < 50; n++) begin
			@(posedge mclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			if (bvalid === 1'h1) break;
		end
		e = bresp;
		bready <= 1'h0;
		tmo(n);
	endtask
	// Read answer is stalled one cycle to exercise the hold
	task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] e);
		int n;
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'h1;
		for (n = 0; n < 50; n++) begin
			@(posedge mclk);
			if (arready) arvalid <= 1'h0;
			if (rvalid === 1'h1 && rready) break;
			if (rvalid === 1'h1) rready <= 1'h1;
		end
		q = rdata;
		e = rresp;
		rready <= 1'h0;
		tmo(n);
	endtask
	initial begin
		repeat (16) @(posedge mclk);
		rst_n <= 1'h1;
		for (int i = 0; i < 6; i++) begin
			rd(8'(4 * i), d, r);
			chk(d, {16'h0000, rstv(i)});
		end
		$display("reset values done");
		repeat (3) for (int i = 0; i < 6; i++) begin
			v = xs();
			wr(8'(4 * i), v, r);
			rd(8'(4 * i), d, r);
			chk(d, {16'h0000, v[15:0] & msk(i)});
		end
		$display("write readback done");
		wr(IPR_OFF_CTRL0, 32'h00007777, r);
		wstrb <= 4'h1;
		wr(IPR_OFF_CTRL0, 32'h00000000, r);
		wstrb <= 4'hF;
		rd(IPR_OFF_CTRL0, d, r);
		chk(d, 32'h00007700);
		$display("byte lanes done");
		wr(8'h1C, 32'hFFFF, r);
		chk(32'(r), 32'(IPR_RESP_ERR));
		rd(8'h1C, d, r);
		chk({d[29:0], r}, 32'(IPR_RESP_ERR));
		$display("unmapped done");
		for (int t = 0; t < 16; t++) begin
			v = t == 0 ? 32'h1703 : t == 1 ? 32'h1000 : t == 2 ? 32'h0 : xs();
			p = t == 1 ? 4'h5 : t < 3 ? 4'hF : 4'(xs());
			wr(IPR_OFF_CTRL0, v, r);
			raise <= {16'h0000, p};
			repeat (4) @(posedge mclk);
			chk(32'({irq_req, irq_req ? {irq_id, irq_level} : 8'h00}), 32'(win(v[15:0], p)));
		end
		$display("priority select done");
		report_and_stop();
	end
endmodule
